/* design/gfs_pkg.sv */
package gfs_pkg;

    // Bus geometry.
    localparam int ADDR_W = 17;
    localparam int DATA_W = 32;
    localparam int NUM_GPIO = 10;

    // Register indices; byte address is four times the index.
    localparam logic [ADDR_W-1:0] SETUP_IDX  = 17'h000b6;
    localparam logic [ADDR_W-1:0] TEST_IDX   = 17'h04017;
    localparam logic [ADDR_W-1:0] POLAR_IDX  = 17'h04018;
    localparam logic [ADDR_W-1:0] STATUS_IDX = 17'h04019;

    // Setup register fields.
    localparam int SET_SEREN   = 0;
    localparam int SET_SERMODE = 1;
    localparam int SET_REFEN   = 2;
    localparam int SET_CLKEN   = 3;
    localparam int SET_CLKOUT0 = 4;
    localparam int SET_CLKOUT1 = 5;
    localparam int SET_EDGE0   = 6;
    localparam int SET_EDGE1   = 7;

    // Test register fields.
    localparam int TST_IND_LSB = 0;
    localparam int TST_FS_LSB  = 4;

    // Polarity register fields.
    localparam int POL_IRQ0 = 0;
    localparam int POL_IRQ1 = 1;

    // Status register fields.
    localparam int STS_CLK_IDLE = 0;
    localparam int STS_PU_OFF   = 1;
    localparam int STS_SCAN     = 2;

    // Values after reset.
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [6:0] TEST_RST  = 7'h0f;
    localparam logic [1:0] POLAR_RST = 2'h0;

    // Pin positions with fixed special roles.
    localparam int PIN_CLK_A = 4;
    localparam int PIN_CLK_B = 6;
    localparam int PIN_REF   = 3;

    // Answer codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* design/gfs_pin_mux.sv */
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Edge bit of irq one clear: single chosen-polarity edge; set: any edge.
// - Edge bit of irq zero clear: single chosen-polarity edge; set: both edges.
// - Invert selected interrupt source when its polarity bit is one.
// - Clock pin select bit zero makes GPIO4 clock out, bit one GPIO6.
// - A set clock pin select outranks port and serial use of the pin.
// - Clock enable only gates the waveform, never configures a pin.
// - Clearing clock enable finishes the current period, then holds zero.
// - Reference enable forces GPIO3 to an input carrying the reference clock.
// - Reference enable bypasses SPI use of GPIO3.
// - Serial mode bit is ignored unless serial enable is one.
// - Mode zero gives GPIO3..0 to SPI, mode one gives GPIO2..1 to I2C.
// - Three-wire SPI uses only GPIO3..1 and leaves GPIO0 free.
// - Latched pull-up-off turns off pull-ups on GPIO1 and GPIO2.
// - Serial enable gives selected pins priority over port data and direction.
// - Test force/sense field reads out as zero in scan mode.
// - Test pin index selects GPIO by number and resets to all ones.
// - Test index decodes one-hot; all outputs zero in scan mode.
// - Index values zero to nine select GPIO0 to GPIO9.
module gfs_pin_mux #(
    parameter int NG = gfs_pkg::NUM_GPIO
) (
    // Clock and reset.
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // Register bus.
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [gfs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    input  wire logic [gfs_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    output logic [1:0]                      s_axi_bresp,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    input  wire logic [gfs_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic [gfs_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    // Pads.
    input  wire logic [NG-1:0]              gpio_i,
    output logic [NG-1:0]                   gpio_o,
    output logic [NG-1:0]                   gpio_oe,
    output logic [NG-1:0]                   pullup_off,
    input  wire logic                       pad_pullup_off,
    input  wire logic                       scan_mode,
    // Ordinary port control.
    input  wire logic [NG-1:0]              port_data_reg,
    input  wire logic [NG-1:0]              port_direction_reg,
    // Serial engines.
    input  wire logic                       spi_three_wire,
    input  wire logic [3:0]                 spi_o,
    input  wire logic [3:0]                 spi_oe,
    output logic [3:0]                      spi_i,
    input  wire logic [2:1]                 i2c_o,
    input  wire logic [2:1]                 i2c_oe,
    output logic [2:1]                      i2c_i,
    // Clocks.
    input  wire logic                       div_clk,
    output logic                            ref_clk,
    output logic                            ref_clk_en,
    // Interrupt sources and requests.
    input  wire logic                       irq0_src,
    input  wire logic                       irq1_src,
    output logic                            ext_irq_zero,
    output logic                            ext_irq_one,
    // Test selector.
    output logic [2:0]                      test_force_sense,
    output logic [NG-1:0]                   test_pin_sel
);
    import gfs_pkg::*;

    typedef struct packed {
        logic [7:0]        setup;
        logic [6:0]        test;
        logic [1:0]        polar;
        logic              aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_got;
        logic [7:0]        wdata;
        logic              wlane;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [7:0]        rdata;
        logic [1:0]        rresp;
        logic [1:0]        irq_s1;
        logic [1:0]        irq_s2;
        logic [1:0]        irq_prev;
        logic [1:0]        irq_pulse;
        logic [NG-1:0]     gi_s1;
        logic [NG-1:0]     gi_s2;
        logic              pu_s1;
        logic              pu_s2;
        logic              scan_s1;
        logic              scan_s2;
        logic              run;
        logic              clk_out;
        logic [NG-1:0]     pin_o;
        logic [NG-1:0]     pin_oe;
    } gfs_state_type;

    gfs_state_type st_ff;
    gfs_state_type nxt_st;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [ADDR_W-1:0] word_idx(
        input logic [ADDR_W-1:0] a
    );
        word_idx = {2'b00, a[ADDR_W-1:2]};
    endfunction

    function automatic logic edge_hit(
        input logic cur,
        input logic prev,
        input logic any_edge
    );
        edge_hit = any_edge ? (cur ^ prev) : (cur & ~prev);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    logic          wr_fire;
    logic          ser_en;
    logic          spi_sel;
    logic          i2c_sel;
    logic [1:0]    irq_lvl;
    logic [NG-1:0] sel_onehot;

    always_comb begin
        nxt_st = st_ff;
        wr_fire = 1'b0;
        // Register bus: address and data taken in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = word_idx(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata[7:0];
            nxt_st.wlane = s_axi_wstrb[0];
        end
        if (st_ff.aw_got && st_ff.w_got) begin
            wr_fire = 1'b1;
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = RESP_OKAY;
            unique case (st_ff.aw_addr)
                SETUP_IDX: begin
                    if (st_ff.wlane) begin
                        nxt_st.setup = st_ff.wdata;
                    end
                end
                TEST_IDX: begin
                    if (st_ff.wlane) begin
                        nxt_st.test = st_ff.wdata[6:0];
                    end
                end
                POLAR_IDX: begin
                    if (st_ff.wlane) begin
                        nxt_st.polar = st_ff.wdata[1:0];
                    end
                end
                STATUS_IDX: ;
                default: nxt_st.bresp = RESP_SLVERR;
            endcase
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = RESP_OKAY;
            nxt_st.rdata = 8'h00;
            unique case (word_idx(s_axi_araddr))
                SETUP_IDX:  nxt_st.rdata = st_ff.setup;
                TEST_IDX:   nxt_st.rdata = {1'b0, st_ff.test};
                POLAR_IDX:  nxt_st.rdata = {6'h00, st_ff.polar};
                STATUS_IDX: nxt_st.rdata = {5'h00, st_ff.scan_s2,
                                            st_ff.pu_s2,
                                            ~st_ff.run & ~st_ff.clk_out};
                default:    nxt_st.rresp = RESP_SLVERR;
            endcase
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end

        // Synchronisers for everything that arrives from the pads.
        nxt_st.irq_s1 = {irq1_src, irq0_src};
        nxt_st.irq_s2 = st_ff.irq_s1;
        nxt_st.gi_s1 = gpio_i;
        nxt_st.gi_s2 = st_ff.gi_s1;
        nxt_st.pu_s1 = pad_pullup_off;
        nxt_st.pu_s2 = st_ff.pu_s1;
        nxt_st.scan_s1 = scan_mode;
        nxt_st.scan_s2 = st_ff.scan_s1;

        // Interrupt edge detection after optional inversion.
        irq_lvl = st_ff.irq_s2 ^ st_ff.polar;
        nxt_st.irq_prev = irq_lvl;
        nxt_st.irq_pulse[0] = edge_hit(irq_lvl[0], st_ff.irq_prev[0],
                                       st_ff.setup[SET_EDGE0]);
        nxt_st.irq_pulse[1] = edge_hit(irq_lvl[1], st_ff.irq_prev[1],
                                       st_ff.setup[SET_EDGE1]);

        // Clock gate: the enable is only sampled while the waveform is low,
        // so a running period always completes before the output parks.
        if (!div_clk) begin
            nxt_st.run = st_ff.setup[SET_CLKEN];
        end
        nxt_st.clk_out = div_clk & nxt_st.run;

        // Pin ownership, lowest priority first.
        ser_en = st_ff.setup[SET_SEREN];
        spi_sel = ser_en & ~st_ff.setup[SET_SERMODE];
        i2c_sel = ser_en & st_ff.setup[SET_SERMODE];
        nxt_st.pin_o = port_data_reg;
        nxt_st.pin_oe = port_direction_reg;
        for (int i = 0; i < 4; i++) begin
            if (spi_sel && !(i == 0 && spi_three_wire)) begin
                nxt_st.pin_o[i] = spi_o[i];
                nxt_st.pin_oe[i] = spi_oe[i];
            end
        end
        for (int i = 1; i < 3; i++) begin
            if (i2c_sel) begin
                nxt_st.pin_o[i] = i2c_o[i];
                nxt_st.pin_oe[i] = i2c_oe[i];
            end
        end
        if (st_ff.setup[SET_REFEN]) begin
            nxt_st.pin_o[PIN_REF] = 1'b0;
            nxt_st.pin_oe[PIN_REF] = 1'b0;
        end
        if (st_ff.setup[SET_CLKOUT0]) begin
            nxt_st.pin_o[PIN_CLK_A] = nxt_st.clk_out;
            nxt_st.pin_oe[PIN_CLK_A] = 1'b1;
        end
        if (st_ff.setup[SET_CLKOUT1]) begin
            nxt_st.pin_o[PIN_CLK_B] = nxt_st.clk_out;
            nxt_st.pin_oe[PIN_CLK_B] = 1'b1;
        end

        if (!aresetn) begin
            nxt_st = '0;
            nxt_st.setup = SETUP_RST;
            nxt_st.test = TEST_RST;
            nxt_st.polar = POLAR_RST;
        end
    end

    always_ff @(posedge aclk) begin
        st_ff <= nxt_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    always_comb begin
        sel_onehot = '0;
        for (int i = 0; i < NG; i++) begin
            if (st_ff.test[3:0] == 4'(i)) begin
                sel_onehot[i] = 1'b1;
            end
        end
    end

    assign s_axi_awready = ~st_ff.aw_got & ~st_ff.bvalid;
    assign s_axi_wready = ~st_ff.w_got & ~st_ff.bvalid;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = ~st_ff.rvalid;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = {24'h000000, st_ff.rdata};
    assign s_axi_rresp = st_ff.rresp;

    assign gpio_o = st_ff.pin_o;
    assign gpio_oe = st_ff.pin_oe;
    assign pullup_off = {{(NG-3){1'b0}}, {2{st_ff.pu_s2}}, 1'b0};
    assign spi_i = st_ff.gi_s2[3:0];
    assign i2c_i = st_ff.gi_s2[2:1];
    assign ref_clk_en = st_ff.setup[SET_REFEN];
    assign ref_clk = st_ff.gi_s2[PIN_REF] & st_ff.setup[SET_REFEN];
    assign ext_irq_zero = st_ff.irq_pulse[0];
    assign ext_irq_one = st_ff.irq_pulse[1];
    assign test_force_sense = st_ff.scan_s2 ? 3'h0 : st_ff.test[6:4];
    assign test_pin_sel = st_ff.scan_s2 ? '0 : sel_onehot;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence clk_low_en_off;
        !div_clk && !st_ff.setup[SET_CLKEN];
    endsequence

    clk_park_a: assert property (
        clk_low_en_off ##1 !st_ff.setup[SET_CLKEN] |=> !st_ff.clk_out
        ) else $error("clock output not parked after disable");
    clk_gate_a: assert property (
        st_ff.clk_out |-> $past(div_clk)
        ) else $error("clock output high without waveform");
    clk_pin_a: assert property (
        st_ff.setup[SET_CLKOUT0] && !wr_fire |=>
        gpio_oe[PIN_CLK_A] && gpio_o[PIN_CLK_A] == st_ff.clk_out
        ) else $error("clock pin A not driven by clock");
    ref_in_a: assert property (
        st_ff.setup[SET_REFEN] && !wr_fire |=> !gpio_oe[PIN_REF]
        ) else $error("reference pin driven");
    irq0_any_a: assert property (
        st_ff.setup[SET_EDGE0] && $stable(st_ff.polar) &&
        $changed(st_ff.irq_s2[0]) |=> ext_irq_zero
        ) else $error("irq zero any-edge missed");
    irq1_one_a: assert property (
        ext_irq_one |-> ($past(irq_lvl[1], 2) != $past(irq_lvl[1]) &&
        ($past(st_ff.setup[SET_EDGE1]) || $past(irq_lvl[1]))) ##1
        (!ext_irq_one || $past(irq_lvl[1], 2) != $past(irq_lvl[1]))
        ) else $error("irq one pulse without edge");
    scan_mask_a: assert property (
        st_ff.scan_s2 |-> test_pin_sel == '0 && test_force_sense == 3'h0
        ) else $error("test outputs in scan");
    one_hot_a: assert property (
        !st_ff.scan_s2 && st_ff.test[3:0] < 4'(NG) |-> $onehot(test_pin_sel)
        ) else $error("test select not one-hot");
    rsv_bit_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == '0
        ) else $error("upper read bits not zero");
    ser_gate_a: assert property (
        !st_ff.setup[SET_SEREN] && !wr_fire && !st_ff.setup[SET_REFEN] &&
        !st_ff.setup[SET_CLKOUT0] |=>
        gpio_oe[2:0] == $past(port_direction_reg[2:0])
        ) else $error("serial took pins while disabled");

endmodule
`default_nettype wire

/* tb/test_gpio_function_select_and_test_mux.sv */
`timescale 1ns/1ns
`default_nettype none
module test_gpio_function_select_and_test_mux;
    import gfs_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Addresses and fixed port settings.
    localparam logic [ADDR_W-1:0] A_SET = SETUP_IDX << 2;
    localparam logic [ADDR_W-1:0] A_TST = TEST_IDX << 2;
    localparam logic [ADDR_W-1:0] A_POL = POLAR_IDX << 2;
    localparam logic [ADDR_W-1:0] A_STS = STATUS_IDX << 2;
    localparam logic [ADDR_W-1:0] A_BAD = 17'h00100;
    localparam logic [9:0]        PD    = 10'h2aa;
    localparam logic [9:0]        PDIR  = 10'h3af;
    logic              aclk, aresetn, pad_pullup_off, scan_mode;
    logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic              s_axi_arvalid, s_axi_rready, s_axi_rvalid;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic              s_axi_arready, spi_three_wire, div_clk;
    logic              ref_clk, ref_clk_en, irq0_src, irq1_src;
    logic              ext_irq_zero, ext_irq_one;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [2:0]        s_axi_awprot, s_axi_arprot, test_force_sense;
    logic [3:0]        s_axi_wstrb, spi_o, spi_oe, spi_i;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [9:0]        gpio_i, gpio_o, gpio_oe, pullup_off, test_pin_sel;
    logic [9:0]        port_data_reg, port_direction_reg;
    logic [2:1]        i2c_o, i2c_oe, i2c_i;
    logic [7:0]        c0, c1;
    logic [3:0]        ck;
    int                error_cnt, check_count;
    gfs_pin_mux #(.NG(NUM_GPIO)) DUT (
        .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .gpio_i, .gpio_o, .gpio_oe, .pullup_off, .pad_pullup_off, .scan_mode,
        .port_data_reg, .port_direction_reg, .spi_three_wire, .spi_o,
        .spi_oe, .spi_i, .i2c_o, .i2c_oe, .i2c_i, .div_clk, .ref_clk,
        .ref_clk_en, .irq0_src, .irq1_src, .ext_irq_zero, .ext_irq_one,
        .test_force_sense, .test_pin_sel
    );
    assign ck = {gpio_oe[6], gpio_oe[4], gpio_o[6], gpio_o[4]};
    ////////////////////////////////////////////////////////////////////////
    // Clock, request counters and watchdog.
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (aresetn !== 1'b1) begin
            c0 <= 8'h00;
            c1 <= 8'h00;
        end else begin
            if (ext_irq_zero === 1'b1) c0 <= c0 + 8'h01;
            if (ext_irq_one === 1'b1) c1 <= c1 + 8'h01;
        end
    end
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////
    // Shared tasks.
    task automatic results();
        if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic wr(input logic [16:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        logic ah, wh, bh;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_bready  <= 1'b1;
        n = 0;
        bh = 1'b0;
        while (!bh && n < 100) begin
            @(negedge aclk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid && s_axi_bready;
            if (bh) chk(32'(s_axi_bresp), 32'(er));
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) s_axi_bready <= 1'b0;
            n++;
        end
        if (!bh) chk(32'h0, 32'h1);
    endtask
    task automatic rd(input logic [16:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        logic ah, rh;
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        n = 0;
        rh = 1'b0;
        while (!rh && n < 100) begin
            @(negedge aclk);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid && s_axi_rready;
            if (rh) chk(s_axi_rdata, ed);
            if (rh) chk(32'(s_axi_rresp), 32'(er));
            @(posedge aclk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) s_axi_rready <= 1'b0;
            n++;
        end
        if (!rh) chk(32'h0, 32'h1);
    endtask
    task automatic pins(input logic [7:0] s, input logic tw,
                        input logic [3:0] eo, input logic [3:0] eoe);
        wr(A_SET, 32'(s), RESP_OKAY);
        @(posedge aclk);
        spi_three_wire <= tw;
        tk(3);
        chk(32'(gpio_o), 32'({PD[9:4], eo}));
        chk(32'(gpio_oe), 32'({PDIR[9:4], eoe}));
    endtask
    task automatic irq(input logic [7:0] s, input logic [1:0] pol,
                       input logic [31:0] exp);
        logic [15:0] b, m, e;
        wr(A_SET, 32'(s), RESP_OKAY);
        wr(A_POL, 32'(pol), RESP_OKAY);
        tk(6);
        b = {c1, c0};
        @(posedge aclk);
        irq0_src <= 1'b1;
        irq1_src <= 1'b1;
        tk(6);
        m = {c1, c0};
        @(posedge aclk);
        irq0_src <= 1'b0;
        irq1_src <= 1'b0;
        tk(6);
        e = {c1, c0};
        chk({m - b, e - m}, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Test sequence.
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, div_clk} = 3'h0;
        {pad_pullup_off, scan_mode, spi_three_wire} = 3'h0;
        {irq0_src, irq1_src} = 2'h0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_awprot = 3'h0;
        s_axi_arprot = 3'h0;
        s_axi_wstrb = 4'hf;
        gpio_i = 10'h000;
        port_data_reg = PD;
        port_direction_reg = PDIR;
        spi_o = 4'h5;
        spi_oe = 4'ha;
        i2c_o = 2'b10;
        i2c_oe = 2'b01;
        error_cnt = 0;
        check_count = 0;
        aresetn = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_SET, 32'h00, RESP_OKAY);
        rd(A_TST, 32'h0f, RESP_OKAY);
        rd(A_POL, 32'h00, RESP_OKAY);
        chk(32'(test_pin_sel), 32'h0);
        chk(32'(pullup_off), 32'h000);
        wr(A_BAD, 32'h5a, RESP_SLVERR);
        rd(A_BAD, 32'h00, RESP_SLVERR);
        for (int i = 0; i < 16; i++) begin
            wr(A_TST, 32'((i << 4) | i), RESP_OKAY);
            tk(3);
            chk(32'(test_pin_sel), (i < 10) ? (32'h1 << i) : 32'h0);
            chk(32'(test_force_sense), 32'(i & 7));
        end
        rd(A_TST, 32'h7f, RESP_OKAY);
        wr(A_TST, 32'h75, RESP_OKAY);
        @(posedge aclk);
        scan_mode <= 1'b1;
        tk(4);
        chk(32'(test_force_sense), 32'h0);
        chk(32'(test_pin_sel), 32'h0);
        @(posedge aclk);
        scan_mode <= 1'b0;
        tk(4);
        chk(32'(test_pin_sel), 32'h020);
        chk(32'(test_force_sense), 32'h7);
        pins(8'h00, 1'b0, 4'ha, 4'hf);
        pins(8'h02, 1'b0, 4'ha, 4'hf);
        pins(8'h01, 1'b0, 4'h5, 4'ha);
        pins(8'h01, 1'b1, 4'h4, 4'hb);
        @(posedge aclk);
        pad_pullup_off <= 1'b1;
        pins(8'h03, 1'b0, 4'hc, 4'hb);
        wr(A_SET, 32'h05, RESP_OKAY);
        @(posedge aclk);
        gpio_i <= 10'h00e;
        tk(5);
        chk(32'(gpio_oe), 32'({PDIR[9:4], 4'h2}));
        chk(32'({i2c_i, spi_i}), 32'h3e);
        chk(32'({ref_clk, ref_clk_en}), 32'h3);
        @(posedge aclk);
        gpio_i <= 10'h000;
        tk(5);
        chk(32'(ref_clk), 32'h0);
        wr(A_SET, 32'h08, RESP_OKAY);
        @(posedge aclk);
        div_clk <= 1'b1;
        tk(3);
        chk(32'(pullup_off), 32'h006);
        chk(32'(ck), 32'h0);
        wr(A_SET, 32'h18, RESP_OKAY);
        tk(3);
        chk(32'(ck), 32'h5);
        wr(A_SET, 32'h38, RESP_OKAY);
        tk(3);
        chk(32'(ck), 32'hf);
        wr(A_SET, 32'h30, RESP_OKAY);
        tk(3);
        chk(32'(ck), 32'hf);
        @(posedge aclk);
        div_clk <= 1'b0;
        tk(3);
        chk(32'(ck), 32'hc);
        @(posedge aclk);
        div_clk <= 1'b1;
        tk(3);
        chk(32'(ck), 32'hc);
        rd(A_STS, 32'h03, RESP_OKAY);
        irq(8'h00, 2'b00, 32'h01010000);
        irq(8'h00, 2'b11, 32'h00000101);
        irq(8'hc0, 2'b00, 32'h01010101);
        irq(8'h80, 2'b01, 32'h01000101);
        results();
    end
endmodule
`default_nettype wire
